//--- logic/gpc_port_top.sv
// gpio ports a to c with the port a request register
`timescale 1ns/100ps
`default_nettype none
module gpc_port_top
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] bus_addr,
  input wire logic bus_wr_en,
  input wire logic bus_rd_en,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  input wire logic [23:0] alt_out,
  input wire logic [23:0] alt_oe,
  input wire logic cmp_req,
  input wire logic global_irq_en,
  output logic cpu_irq
);
  logic [7:0] req_q;
  logic [7:0] req_d;
  logic [7:0] req_set;
  logic [7:0] req_clr;
  logic [7:0] rdata_d;
  logic req_hit;

  gpc_port_if pif[GPC_PORTS] ();

  // ----------------------------------------
  // port slices
  // ----------------------------------------
  for (genvar g = 0; g < GPC_PORTS; g++) begin : g_port
    assign pif[g].idx_wr = bus_wr_en && bus_addr == GPC_IDX_ADDR[g];
    assign pif[g].win_wr = bus_wr_en && bus_addr == GPC_WIN_ADDR[g];
    assign pif[g].out_wr = bus_wr_en && bus_addr == GPC_OUT_ADDR[g];
    assign pif[g].wdata = bus_wdata;
    gpc_port_slice u_slice (
      .clk(clk),
      .rst_n(rst_n),
      .p(pif[g]),
      .pin_in(pin_in[8*g +: 8]),
      .alt_out(alt_out[8*g +: 8]),
      .alt_oe(alt_oe[8*g +: 8]),
      .pin_out(pin_out[8*g +: 8]),
      .pin_oe(pin_oe[8*g +: 8])
    );
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] win_rd [GPC_PORTS];
  logic [7:0] idx_rd [GPC_PORTS];
  logic [7:0] in_rd [GPC_PORTS];
  logic [7:0] out_rd [GPC_PORTS];
  for (genvar g = 0; g < GPC_PORTS; g++) begin : g_rd
    assign win_rd[g] = pif[g].win_rdata;
    assign idx_rd[g] = pif[g].idx_q;
    assign in_rd[g] = pif[g].in_data;
    assign out_rd[g] = pif[g].out_data;
  end

  always_comb begin
    rdata_d = 8'h00;
    if (bus_addr == GPC_REQ_ADDR) rdata_d = req_q;
    for (int i = 0; i < GPC_PORTS; i++) begin
      if (bus_addr == GPC_WIN_ADDR[i]) rdata_d = win_rd[i];
      if (bus_addr == GPC_IDX_ADDR[i]) rdata_d = idx_rd[i];
      if (bus_addr == GPC_IN_ADDR[i]) rdata_d = in_rd[i];
      if (bus_addr == GPC_OUT_ADDR[i]) rdata_d = out_rd[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) bus_rdata <= 8'h00;
    else if (bus_rd_en) bus_rdata <= rdata_d;
  end

  // ----------------------------------------
  // port a request register
  // ----------------------------------------
  assign req_hit = bus_wr_en && bus_addr == GPC_REQ_ADDR;
  assign req_clr = req_hit ? bus_wdata : 8'h00;

  always_comb begin
    req_set = pif[0].rise;
    req_set[GPC_CMP_BIT] = pif[0].rise[GPC_CMP_BIT] | cmp_req;
    req_d = (req_q & ~req_clr) | req_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) req_q <= GPC_RST_REQ;
    else req_q <= req_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) cpu_irq <= 1'b0;
    else cpu_irq <= global_irq_en && (req_q != 8'h00);
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // window write with the direction index selected on port a
  sequence s_win_dir_wr;
    bus_wr_en && bus_addr == GPC_WIN_ADDR[0] && idx_rd[0] == GPC_IDX_DIR;
  endsequence
  // one idle cycle, then a window read on port a
  sequence s_win_rd;
    !bus_wr_en ##1 bus_rd_en && bus_addr == GPC_WIN_ADDR[0] && !bus_wr_en;
  endsequence

  a_win_dir: assert property (@(posedge clk) disable iff (!rst_n)
    s_win_dir_wr ##1 s_win_rd |=> bus_rdata == $past(bus_wdata, 3))
    else $error("window does not reach direction sub-register");
  a_win_read: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd_en && bus_addr == GPC_WIN_ADDR[1] |=> bus_rdata == $past(win_rd[1]))
    else $error("window read returns wrong sub-register");
  a_req_set: assert property (@(posedge clk) disable iff (!rst_n)
    pif[0].rise[3] |=> req_q[3])
    else $error("pin request not latched");
  a_req_bit7: assert property (@(posedge clk) disable iff (!rst_n)
    pif[0].rise[7] |=> req_q[7])
    else $error("pin 7 request not latched");
  a_cmp_bit: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_req |=> req_q[GPC_CMP_BIT])
    else $error("comparator request not latched");
  a_req_hold: assert property (@(posedge clk) disable iff (!rst_n)
    req_q[0] && !(req_hit && bus_wdata[0]) |=> req_q[0])
    else $error("pending request lost without clear");
  a_fwd_core: assert property (@(posedge clk) disable iff (!rst_n)
    global_irq_en && req_q != 8'h00 |=> cpu_irq)
    else $error("pending request not forwarded");
  a_poll_mode: assert property (@(posedge clk) disable iff (!rst_n)
    !global_irq_en |=> !cpu_irq)
    else $error("request forwarded while disabled");
  a_poll_read: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd_en && bus_addr == GPC_REQ_ADDR |=> bus_rdata == $past(req_q))
    else $error("request read does not return latched bits");
endmodule // gpc_port_top
`default_nettype wire

//--- logic/gpc_pkg.sv
// constants for the gpio port block
package gpc_pkg;
  localparam int unsigned GPC_PORTS = 3;
  localparam logic [11:0] GPC_REQ_ADDR = 12'hfc3;
  localparam logic [11:0] GPC_WIN_ADDR [GPC_PORTS] = '{12'hfd1, 12'hfd5, 12'hfd9};
  localparam logic [11:0] GPC_IDX_ADDR [GPC_PORTS] = '{12'hfd0, 12'hfd4, 12'hfd8};
  localparam logic [11:0] GPC_IN_ADDR [GPC_PORTS] = '{12'hfd2, 12'hfd6, 12'hfda};
  localparam logic [11:0] GPC_OUT_ADDR [GPC_PORTS] = '{12'hfd3, 12'hfd7, 12'hfdb};
  localparam logic [7:0] GPC_IDX_DIR = 8'h01;
  localparam logic [7:0] GPC_IDX_ALT = 8'h02;
  localparam logic [7:0] GPC_RST_IDX = 8'h00;
  localparam logic [7:0] GPC_RST_DIR = 8'hff;
  localparam logic [7:0] GPC_RST_ALT = 8'h00;
  localparam logic [7:0] GPC_RST_OUT = 8'h00;
  localparam logic [7:0] GPC_RST_REQ = 8'h00;
  localparam int unsigned GPC_CMP_BIT = 6;
  localparam int unsigned GPC_SYNC_LAT = 3;
endpackage

//--- logic/gpc_port_if.sv
// link between the register core and one port slice
`timescale 1ns/100ps
`default_nettype none
interface gpc_port_if;
  logic idx_wr;
  logic win_wr;
  logic out_wr;
  logic [7:0] wdata;
  logic [7:0] idx_q;
  logic [7:0] win_rdata;
  logic [7:0] in_data;
  logic [7:0] out_data;
  logic [7:0] rise;
  modport core (output idx_wr, win_wr, out_wr, wdata,
                input idx_q, win_rdata, in_data, out_data, rise);
  modport slice (input idx_wr, win_wr, out_wr, wdata,
                 output idx_q, win_rdata, in_data, out_data, rise);
endinterface
`default_nettype wire

//--- logic/gpc_port_slice.sv
// one gpio port: sub-registers, synchroniser and pin drive
`timescale 1ns/100ps
`default_nettype none
module gpc_port_slice
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  gpc_port_if.slice p,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe
);
  logic [7:0] idx_q;
  logic [7:0] dir_q;
  logic [7:0] alt_q;
  logic [7:0] out_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] prev_q;
  logic [7:0] in_q;

  // ----------------------------------------
  // sub-register index and window
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) idx_q <= GPC_RST_IDX;
    else if (p.idx_wr) idx_q <= p.wdata;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) dir_q <= GPC_RST_DIR;
    else if (p.win_wr && idx_q == GPC_IDX_DIR) dir_q <= p.wdata;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) alt_q <= GPC_RST_ALT;
    else if (p.win_wr && idx_q == GPC_IDX_ALT) alt_q <= p.wdata;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) out_q <= GPC_RST_OUT;
    else if (p.out_wr) out_q <= p.wdata;
  end

  always_comb begin
    unique case (idx_q)
      GPC_IDX_DIR: p.win_rdata = dir_q;
      GPC_IDX_ALT: p.win_rdata = alt_q;
      default: p.win_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      prev_q <= 8'h00;
      in_q <= 8'h00;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      in_q <= sync2_q;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_oe <= 8'h00;
      pin_out <= 8'h00;
    end else begin
      pin_oe <= (alt_q & alt_oe) | (~alt_q & ~dir_q);
      pin_out <= (alt_q & alt_out) | (~alt_q & out_q);
    end
  end

  assign p.idx_q = idx_q;
  assign p.in_data = in_q;
  assign p.out_data = out_q;
  assign p.rise = sync2_q & ~prev_q;

  a_alt_prio: assert property (@(posedge clk) disable iff (!rst_n)
    pin_oe == $past((alt_q & alt_oe) | (~alt_q & ~dir_q)))
    else $error("pin enable ignores alternate override");
  a_dir_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (alt_q == 8'h00 && $stable(alt_q)) |=> pin_out == $past(out_q) && pin_oe == ~$past(dir_q))
    else $error("gpio drive does not follow direction");
  a_sync_lat: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n, 3) |-> in_q == $past(pin_in, 3))
    else $error("input data not three cycles after pin");
endmodule // gpc_port_slice
`default_nettype wire

//--- test/gpc_pin_model.sv
// external circuit on the port pins
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_model (
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] ext_lvl,
  output logic [23:0] pin_in
);
  // driven pins read back the port drive, released pins follow the circuit
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // gpc_pin_model
`default_nettype wire

//--- test/gpc_port_top_test.sv
// self-checking bench for the gpio port block
`timescale 1ns/100ps
`default_nettype none
module gpc_port_top_test;
  import gpc_pkg::*;
  logic clk, rst_n, bus_wr_en, bus_rd_en, cmp_req, global_irq_en, cpu_irq;
  logic [11:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, r, v;
  logic [23:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, ext_lvl;
  logic [7:0] m_dir [3], m_alt [3], m_out [3];
  int err_total, tests_run, cyc, seed;
  gpc_port_top gpc_port_top_inst (.clk, .rst_n, .bus_addr, .bus_wr_en, .bus_rd_en,
    .bus_wdata, .bus_rdata, .pin_in, .pin_out, .pin_oe, .alt_out, .alt_oe, .cmp_req,
    .global_irq_en, .cpu_irq);
  gpc_pin_model gpc_pin_model_inst (.pin_out, .pin_oe, .ext_lvl, .pin_in);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------
  // tasks
  // ----------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr_en <= 1'b1;
    @(posedge clk);
    bus_wr_en <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_addr <= a;
    bus_rd_en <= 1'b1;
    @(posedge clk);
    bus_rd_en <= 1'b0;
    #1 r = bus_rdata;
    chk($sformatf("read %h", a), {16'h0000, e}, {16'h0000, r});
  endtask
  task automatic chk_pins();
    logic [23:0] eo, ed, lv;
    repeat (5) @(posedge clk);
    for (int p = 0; p < 3; p++) begin
      eo[p*8+:8] = (m_alt[p] & alt_oe[p*8+:8]) | (~m_alt[p] & ~m_dir[p]);
      ed[p*8+:8] = (m_alt[p] & alt_out[p*8+:8]) | (~m_alt[p] & m_out[p]);
    end
    lv = (eo & ed) | (~eo & ext_lvl);
    #1;
    chk("pin_oe", eo, pin_oe);
    chk("pin_out", ed, pin_out);
    for (int p = 0; p < 3; p++) begin
      rdchk(GPC_IN_ADDR[p], lv[p*8+:8]);
    end
  endtask
  task automatic set_sub(input int p, input logic [7:0] i, input logic [7:0] d);
    wr(GPC_IDX_ADDR[p], i);
    wr(GPC_WIN_ADDR[p], d);
    rdchk(GPC_WIN_ADDR[p], d);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    seed = 20614;
    {rst_n, bus_wr_en, bus_rd_en, cmp_req, global_irq_en} = 5'h00;
    {bus_addr, bus_wdata} = 20'h00000;
    {alt_out, alt_oe, ext_lvl} = 72'h0;
    for (int p = 0; p < 3; p++) begin
      {m_dir[p], m_alt[p], m_out[p]} = {GPC_RST_DIR, GPC_RST_ALT, GPC_RST_OUT};
    end
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      rdchk(GPC_WIN_ADDR[p], 8'h00);
      wr(GPC_IDX_ADDR[p], GPC_IDX_DIR);
      rdchk(GPC_WIN_ADDR[p], GPC_RST_DIR);
    end
    rdchk(GPC_REQ_ADDR, GPC_RST_REQ);
    rdchk(12'hfff, 8'h00);
    chk_pins();
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 3; p++) begin
        m_dir[p] = 8'($random(seed));
        m_alt[p] = 8'($random(seed));
        m_out[p] = 8'($random(seed));
        set_sub(p, GPC_IDX_DIR, m_dir[p]);
        set_sub(p, GPC_IDX_ALT, m_alt[p]);
        wr(GPC_OUT_ADDR[p], m_out[p]);
      end
      alt_out <= 24'($random(seed));
      alt_oe <= 24'($random(seed));
      ext_lvl <= 24'($random(seed));
      chk_pins();
    end
    set_sub(0, GPC_IDX_DIR, 8'hff);
    set_sub(0, GPC_IDX_ALT, 8'h00);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'h40 : 8'($random(seed));
      global_irq_en <= 1'b0;
      ext_lvl[7:0] <= 8'h00;
      repeat (6) @(posedge clk);
      wr(GPC_REQ_ADDR, 8'hff);
      ext_lvl[7:0] <= v;
      repeat (6) @(posedge clk);
      #1 chk("cpu_irq", 24'h0, {23'h0, cpu_irq});
      rdchk(GPC_REQ_ADDR, v);
      global_irq_en <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("cpu_irq", {23'h0, v != 8'h00}, {23'h0, cpu_irq});
      wr(GPC_REQ_ADDR, v);
      rdchk(GPC_REQ_ADDR, 8'h00);
    end
    @(posedge clk);
    cmp_req <= 1'b1;
    @(posedge clk);
    cmp_req <= 1'b0;
    rdchk(GPC_REQ_ADDR, 8'h40);
    wrap_up();
  end
endmodule // gpc_port_top_test
`default_nettype wire
